// ==== fcc_client_model.sv ====
`timescale 1ns/1ps
// ----
// Client requesting pause
// ----
module fcc_client_model
(
    input wire logic ref_clk_in, // Clock
    input wire logic [8:0] want_in, // Bit 8 pause, 7:0 prios
    output logic pause_req_out = 1'h0, // Pause request
    output logic [7:0] prio_out = 8'h00 // Prio requests
);
    // Requests are levels moved just after an edge, as client logic would
    always @(posedge ref_clk_in)
    begin
        pause_req_out <= want_in[8];
        prio_out <= want_in[7:0];
    end
endmodule

// ==== fcc_edge.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Per-priority request edge tracker
// ------------------------------------------------------------
module fcc_edge
    import fcc_pkg::*;
(
    input wire logic ref_clk_in, // Clock
    input wire logic srst_in, // Sync reset
    input wire logic [7:0] level_in, // Gated request levels
    output logic [7:0] rise_out, // Rising edge pulse
    output logic [7:0] fall_out // Falling edge pulse
);
    typedef struct packed {
        logic [7:0] prev;
        logic [7:0] rise;
        logic [7:0] fall;
    } fcc_edge_s;

    fcc_edge_s st;
    fcc_edge_s next_st;

    // Edge detect against previous sample
    always_comb
    begin
        next_st = st;
        next_st.prev = level_in;
        next_st.rise = level_in & ~st.prev;
        next_st.fall = ~level_in & st.prev;
    end

    // State register
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign rise_out = st.rise;
    assign fall_out = st.fall;
endmodule

// ==== fcc_flow_ctrl.sv ====
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Flow control configuration and gating
// ------------------------------------------------------------
module fcc_flow_ctrl
    import fcc_pkg::*;
#(
    parameter bit PFC_SUPPORT = 1'b1 // Build with priority flow control
)
(
    input wire logic ref_clk_in, // 100 MHz clock
    input wire logic srst_in, // Sync reset, high
    input wire logic [7:0] addr_in, // Register byte address
    input wire logic [31:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [31:0] rdata_out, // Read data, cycle after strobe
    input wire logic pause_req_in, // Client pause request
    input wire logic tx_prio7_hold_valid, // Client priority 7 request
    input wire logic tx_prio6_hold_valid, // Client priority 6 request
    input wire logic tx_prio5_hold_valid, // Client priority 5 request
    input wire logic tx_prio4_hold_valid, // Client priority 4 request
    input wire logic tx_prio3_hold_valid, // Client priority 3 request
    input wire logic tx_prio2_hold_valid, // Client priority 2 request
    input wire logic tx_prio1_hold_valid, // Client priority 1 request
    input wire logic tx_prio0_hold_valid, // Client priority 0 request
    input wire logic rx_pause_frame_in, // MAC saw a pause frame
    input wire logic rx_pfc_frame_in, // MAC saw a PFC frame
    input wire logic [7:0] rx_pfc_quanta_valid_in, // Priorities with valid quanta
    input wire logic [7:0] rx_pfc_clear_in, // Priorities whose pause expired
    output logic tx_pause_send_out, // Launch pause frame (pulse)
    output logic tx_pause_xon_out, // Launched frame carries zero quanta
    output logic tx_pfc_send_out, // Launch PFC frame (pulse)
    output logic [7:0] tx_pfc_xon_out, // Priorities sent with zero quanta
    output logic [7:0] tx_pfc_xoff_out, // Priorities sent with quanta
    output logic tx_inhibit_out, // Received pause inhibits transmitter
    output logic rx_fwd_to_client_out, // Pass control frame to client
    output logic rx_prio7_hold_valid, // Priority 7 paused
    output logic rx_prio6_hold_valid, // Priority 6 paused
    output logic rx_prio5_hold_valid, // Priority 5 paused
    output logic rx_prio4_hold_valid, // Priority 4 paused
    output logic rx_prio3_hold_valid, // Priority 3 paused
    output logic rx_prio2_hold_valid, // Priority 2 paused
    output logic rx_prio1_hold_valid, // Priority 1 paused
    output logic rx_prio0_hold_valid // Priority 0 paused
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic pause_prev;
        logic pause_send;
        logic pause_xon;
        logic pfc_send;
        logic [7:0] pfc_xon;
        logic [7:0] pfc_xoff;
        logic inhibit;
        logic fwd;
        logic [7:0] rx_hold;
    } fcc_top_s;

    fcc_top_s st;
    fcc_top_s next_st;
    logic [7:0] tx_level;
    logic [7:0] tx_gated;
    logic [7:0] tx_rise;
    logic [7:0] tx_fall;
    logic [31:0] keep_mask;

    // Bits absent without PFC support are never stored, so read as zero
    assign keep_mask = PFC_SUPPORT ? FCC_CFG_WMASK : (FCC_CFG_WMASK & ~FCC_PFC_ONLY_MASK); // R12 R18

    assign tx_level = {tx_prio7_hold_valid, tx_prio6_hold_valid, tx_prio5_hold_valid,
                       tx_prio4_hold_valid, tx_prio3_hold_valid, tx_prio2_hold_valid,
                       tx_prio1_hold_valid, tx_prio0_hold_valid};

    // Disabled priorities are forced low before edge detection
    assign tx_gated = st.cfg[FCC_BIT_TX_PFC] ? // R6
                      (tx_level & st.cfg[FCC_TX_PRIO_LSB +: FCC_NPRIO]) : 8'h00; // R13 R14

    fcc_edge u_edge (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .level_in(tx_gated),
        .rise_out(tx_rise),
        .fall_out(tx_fall)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] rx_en;
        logic [7:0] xon_ok;
        logic pause_lvl;
        rx_en = st.cfg[FCC_RX_PRIO_LSB +: FCC_NPRIO];
        xon_ok = tx_fall & {FCC_NPRIO{st.cfg[FCC_BIT_AUTO_XON]}};
        pause_lvl = pause_req_in & st.cfg[FCC_BIT_TX_PAUSE];
        next_st = st;
        next_st.pause_prev = pause_lvl;
        next_st.rdata = 32'h00000000;

        // Register write: only defined bits are kept
        if (wr_in && addr_in == FCC_ADDR_CFG)
        begin
            next_st.cfg = wdata_in & keep_mask; // R18
        end

        // Register read, data one cycle later; unmapped reads give zero
        if (rd_in)
        begin
            unique case (addr_in)
                FCC_ADDR_CFG: next_st.rdata = st.cfg;
                FCC_ADDR_STATUS: next_st.rdata = {22'h000000, st.fwd, st.inhibit, st.rx_hold};
                default: next_st.rdata = 32'h00000000;
            endcase
        end

        // Standard pause launch; disabled means request ignored
        // XON is sent only while pause is still enabled, so clearing the enable is silent
        next_st.pause_send = (pause_lvl & ~st.pause_prev) // R1 R2
                             | (~pause_lvl & st.pause_prev & st.cfg[FCC_BIT_AUTO_XON] // R11
                                & st.cfg[FCC_BIT_TX_PAUSE]);
        next_st.pause_xon = ~pause_lvl & st.pause_prev;

        // PFC launch on either edge of an enabled priority
        next_st.pfc_xoff = tx_rise; // R5
        next_st.pfc_xon = xon_ok; // R11
        next_st.pfc_send = |tx_rise | |tx_fall; // R13

        // Received pause: act on it or forward it
        next_st.inhibit = rx_pause_frame_in & st.cfg[FCC_BIT_RX_PAUSE]; // R3
        next_st.fwd = (rx_pause_frame_in & ~st.cfg[FCC_BIT_RX_PAUSE]) // R4
                      | (rx_pfc_frame_in & ~st.cfg[FCC_BIT_RX_PFC]); // R8

        // Per-priority receive holds; set wins over expiry clear
        next_st.rx_hold = st.rx_hold & ~rx_pfc_clear_in;
        if (rx_pfc_frame_in && st.cfg[FCC_BIT_RX_PFC])
        begin
            next_st.rx_hold = next_st.rx_hold | rx_pfc_quanta_valid_in; // R7 R15
        end
        // A cleared enable forces the output low on the next clock
        next_st.rx_hold = next_st.rx_hold & rx_en; // R16 R17
        if (!st.cfg[FCC_BIT_RX_PFC])
        begin
            next_st.rx_hold = 8'h00; // R8
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            st <= '0;
            st.cfg <= PFC_SUPPORT ? FCC_CFG_RESET : (FCC_CFG_RESET & ~FCC_PFC_ONLY_MASK); // R12
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign rdata_out = st.rdata;
    assign tx_pause_send_out = st.pause_send;
    assign tx_pause_xon_out = st.pause_xon;
    assign tx_pfc_send_out = st.pfc_send;
    assign tx_pfc_xon_out = st.pfc_xon;
    assign tx_pfc_xoff_out = st.pfc_xoff;
    assign tx_inhibit_out = st.inhibit;
    assign rx_fwd_to_client_out = st.fwd;
    assign rx_prio7_hold_valid = st.rx_hold[7];
    assign rx_prio6_hold_valid = st.rx_hold[6];
    assign rx_prio5_hold_valid = st.rx_hold[5];
    assign rx_prio4_hold_valid = st.rx_hold[4];
    assign rx_prio3_hold_valid = st.rx_hold[3];
    assign rx_prio2_hold_valid = st.rx_hold[2];
    assign rx_prio1_hold_valid = st.rx_hold[1];
    assign rx_prio0_hold_valid = st.rx_hold[0];
endmodule

// ==== fcc_flow_ctrl_props.sv ====
`timescale 1ns/1ps
// ----
// Port checks
// ----
module fcc_flow_ctrl_props
    import fcc_pkg::*;
#(
    parameter bit PFC_SUPPORT = 1'h1 // PFC built in
)
(
    input wire logic ref_clk_in, // Clock
    input wire logic srst_in, // Reset
    input wire logic [7:0] addr_in, // Address
    input wire logic [31:0] wdata_in, // Write data
    input wire logic wr_in, // Write
    input wire logic rd_in, // Read
    input wire logic [31:0] rdata_out, // Read data
    input wire logic pause_req_in, // Pause request
    input wire logic tx_prio3_hold_valid, // Prio 3 request
    input wire logic rx_pause_frame_in, // Pause frame
    input wire logic rx_pfc_frame_in, // PFC frame
    input wire logic [7:0] rx_pfc_quanta_valid_in, // Quanta valid
    input wire logic tx_pause_send_out, // Pause launch
    input wire logic tx_pause_xon_out, // Zero quanta
    input wire logic tx_pfc_send_out, // PFC launch
    input wire logic [7:0] tx_pfc_xoff_out, // Asserted prios
    input wire logic tx_inhibit_out, // Inhibit
    input wire logic rx_fwd_to_client_out, // Forward
    input wire logic rx_prio1_hold_valid, // Prio 1 held
    input wire logic rx_prio0_hold_valid // Prio 0 held
);
    localparam logic [31:0] MASK = PFC_SUPPORT ? FCC_CFG_WMASK : 32'h60000000;
    logic [31:0] cfg;
    // Shadow of the config word, so gating can be judged from ports alone
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            cfg <= FCC_CFG_RESET & MASK;
        else if (wr_in && addr_in == FCC_ADDR_CFG)
            cfg <= wdata_in & MASK;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    sequence pfc_rise_s;
        $rose(tx_prio3_hold_valid) && cfg[26] && cfg[11];
    endsequence
    sequence pfc_launch_s;
        ##2 tx_pfc_send_out && tx_pfc_xoff_out[3];
    endsequence
    pause_send_a: assert property ($rose(pause_req_in) && cfg[30] |=> tx_pause_send_out)
        else $error("pause launch missing");
    pause_off_a: assert property (!cfg[30] |=> !tx_pause_send_out)
        else $error("pause launched while disabled");
    pause_xon_a: assert property ($fell(pause_req_in) && cfg[30] && cfg[20] |=>
        tx_pause_send_out && tx_pause_xon_out) else $error("xon frame missing");
    pfc_launch_a: assert property (pfc_rise_s |-> pfc_launch_s)
        else $error("pfc launch missing");
    pfc_gate_a: assert property (!cfg[26] [*4] |-> !tx_pfc_send_out)
        else $error("pfc launched while disabled");
    rx_inhibit_a: assert property (rx_pause_frame_in && cfg[29] |=> tx_inhibit_out)
        else $error("inhibit missing");
    rx_forward_a: assert property (rx_pause_frame_in && !cfg[29] |=> rx_fwd_to_client_out)
        else $error("forward missing");
    rx_hold_set_a: assert property (rx_pfc_frame_in && cfg[25] && cfg[0] &&
        rx_pfc_quanta_valid_in[0] |=> rx_prio0_hold_valid) else $error("hold missing");
    rx_hold_mask_a: assert property (!cfg[1] |=> !rx_prio1_hold_valid)
        else $error("masked hold set");
    cfg_read_a: assert property (rd_in && addr_in == FCC_ADDR_CFG |=> rdata_out == $past(cfg))
        else $error("config readback wrong");
endmodule

// ==== fcc_pkg.sv ====
//
// Contract
// R1: TX pause enable set: pause request input launches a pause frame.
// R2: TX pause enable clear: pause request input is ignored.
// R3: RX pause enable set: received pause frames inhibit the transmitter.
// R4: RX pause enable clear: received pause frames go to the client.
// R5: TX PFC enable set: enabled priority valid input launches a PFC frame.
// R6: TX PFC enable clear: all priority transmit valid inputs ignored.
// R7: RX PFC enable set: received PFC asserts enabled priority valid outputs.
// R8: RX PFC enable clear: no action on PFC frames, forwarded to client.
// R9: Software should not enable TX pause and TX PFC together.
// R10: Software should not enable RX pause and RX PFC together.
// R11: Auto-XON set: zero-quanta frame sent when enabled request drops.
// R12: Auto-XON and priority enables read zero without PFC support.
// R13: TX priority enables 15..8 map 7..0; both edges launch PFC.
// R14: Cleared TX priority enable ignores that priority valid input.
// R15: RX priority enables 7,6 gate PFC processing for priorities 7,6.
// R16: Cleared RX priority enable holds that receive valid output at 0.
// R17: RX enables 5..0 govern priorities 5..0 like priority 7.
// R18: Reserved bits read zero; writes to them have no effect.
package fcc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] FCC_ADDR_CFG = 8'h00;
    localparam logic [7:0] FCC_ADDR_STATUS = 8'h04;
    localparam int FCC_BIT_TX_PAUSE = 30;
    localparam int FCC_BIT_RX_PAUSE = 29;
    localparam int FCC_BIT_TX_PFC = 26;
    localparam int FCC_BIT_RX_PFC = 25;
    localparam int FCC_BIT_AUTO_XON = 20;
    localparam int FCC_TX_PRIO_LSB = 8;
    localparam int FCC_RX_PRIO_LSB = 0;
    localparam int FCC_NPRIO = 8;
    localparam logic [31:0] FCC_CFG_WMASK = 32'h6610FFFF;
    localparam logic [31:0] FCC_PFC_ONLY_MASK = 32'h0610FFFF;
    localparam logic [31:0] FCC_CFG_RESET = 32'h6010FFFF;

endpackage

// ==== flow_control_config_tb.sv ====
`timescale 1ns/1ps
// ----
// Bench
// ----
module flow_control_config_tb
    import fcc_pkg::*;
;
    logic ref_clk_in = 1'h0;
    logic srst_in = 1'h1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'h0;
    logic rd_in = 1'h0;
    logic rx_p = 1'h0;
    logic rx_f = 1'h0;
    logic [7:0] rx_q = 8'h00;
    logic [7:0] rx_c = 8'h00;
    logic [8:0] want = 9'h000;
    logic pause_req, ps, px, fs, inh, fwd;
    logic [7:0] prio, hold, xoff, xon;
    logic [31:0] rdata_out;
    logic [31:0] rdata_np;
    int miscompares = 0;
    int comparisons = 0;
    int n_ps, n_px, n_fs, n_inh, n_fwd;
    logic [7:0] xoff_seen, xon_seen;
    always #5 ref_clk_in = ~ref_clk_in;
    fcc_client_model client (.ref_clk_in, .want_in(want), .pause_req_out(pause_req),
        .prio_out(prio));
    fcc_flow_ctrl #(.PFC_SUPPORT(1'h1)) dut (.ref_clk_in, .srst_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .pause_req_in(pause_req),
        .tx_prio7_hold_valid(prio[7]), .tx_prio6_hold_valid(prio[6]),
        .tx_prio5_hold_valid(prio[5]), .tx_prio4_hold_valid(prio[4]),
        .tx_prio3_hold_valid(prio[3]), .tx_prio2_hold_valid(prio[2]),
        .tx_prio1_hold_valid(prio[1]), .tx_prio0_hold_valid(prio[0]),
        .rx_pause_frame_in(rx_p), .rx_pfc_frame_in(rx_f), .rx_pfc_quanta_valid_in(rx_q),
        .rx_pfc_clear_in(rx_c), .tx_pause_send_out(ps), .tx_pause_xon_out(px),
        .tx_pfc_send_out(fs), .tx_pfc_xon_out(xon), .tx_pfc_xoff_out(xoff),
        .tx_inhibit_out(inh), .rx_fwd_to_client_out(fwd),
        .rx_prio7_hold_valid(hold[7]), .rx_prio6_hold_valid(hold[6]),
        .rx_prio5_hold_valid(hold[5]), .rx_prio4_hold_valid(hold[4]),
        .rx_prio3_hold_valid(hold[3]), .rx_prio2_hold_valid(hold[2]),
        .rx_prio1_hold_valid(hold[1]), .rx_prio0_hold_valid(hold[0]));
    // A build without PFC support on the same bus shows the cut-down register
    fcc_flow_ctrl #(.PFC_SUPPORT(1'h0)) dut_nopfc (.ref_clk_in, .srst_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out(rdata_np), .pause_req_in(pause_req),
        .tx_prio7_hold_valid(prio[7]), .tx_prio6_hold_valid(prio[6]),
        .tx_prio5_hold_valid(prio[5]), .tx_prio4_hold_valid(prio[4]),
        .tx_prio3_hold_valid(prio[3]), .tx_prio2_hold_valid(prio[2]),
        .tx_prio1_hold_valid(prio[1]), .tx_prio0_hold_valid(prio[0]),
        .rx_pause_frame_in(rx_p), .rx_pfc_frame_in(rx_f), .rx_pfc_quanta_valid_in(rx_q),
        .rx_pfc_clear_in(rx_c), .tx_pause_send_out(), .tx_pause_xon_out(),
        .tx_pfc_send_out(), .tx_pfc_xon_out(), .tx_pfc_xoff_out(),
        .tx_inhibit_out(), .rx_fwd_to_client_out(),
        .rx_prio7_hold_valid(), .rx_prio6_hold_valid(), .rx_prio5_hold_valid(),
        .rx_prio4_hold_valid(), .rx_prio3_hold_valid(), .rx_prio2_hold_valid(),
        .rx_prio1_hold_valid(), .rx_prio0_hold_valid());
    // Count launch pulses; a doubled or lost pulse changes the count
    always @(posedge ref_clk_in)
    begin
        n_ps <= n_ps + ps;
        n_px <= n_px + (ps & px);
        n_fs <= n_fs + fs;
        n_inh <= n_inh + inh;
        n_fwd <= n_fwd + fwd;
        xoff_seen <= xoff_seen | xoff;
        xon_seen <= xon_seen | xon;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic clr();
        {n_ps, n_px, n_fs, n_inh, n_fwd} = '0;
        {xoff_seen, xon_seen} = 16'h0000;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge ref_clk_in);
        wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge ref_clk_in);
        rd_in <= 1'h0;
        #1;
        chk("rdata", e, rdata_out);
    endtask
    // Client requests change at the next edge after want; the step waits n edges in all
    task automatic step(input logic [8:0] w, input int n);
        #1;
        clr();
        want = w;
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic rxf(input logic p, input logic f, input logic [7:0] q, input logic [7:0] c);
        @(posedge ref_clk_in);
        #1;
        clr();
        @(posedge ref_clk_in);
        {rx_p, rx_f, rx_q, rx_c} <= {p, f, q, c};
        @(posedge ref_clk_in);
        {rx_p, rx_f, rx_q, rx_c} <= 18'h0;
        repeat (3) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence: never both pause and PFC on one direction at once
    initial
    begin
        clr();
        repeat (20) @(posedge ref_clk_in);
        srst_in <= 1'h0;
        rd(FCC_ADDR_CFG, FCC_CFG_RESET);
        chk("rdata_nopfc", FCC_CFG_RESET & ~FCC_PFC_ONLY_MASK, rdata_np);
        wr(FCC_ADDR_CFG, 32'h9FEFFFFF);
        rd(FCC_ADDR_CFG, 32'h0600FFFF);
        chk("rdata_nopfc", 32'h00000000, rdata_np);
        rd(8'h08, 32'h0);
        wr(FCC_ADDR_CFG, 32'h40100000);
        step(9'h100, 5);
        chk("pause_send", 1, n_ps + n_px);
        step(9'h000, 5);
        chk("pause_xon", 1, n_px);
        wr(FCC_ADDR_CFG, 32'h0);
        step(9'h100, 5);
        chk("pause_off", 0, n_ps);
        step(9'h000, 2);
        wr(FCC_ADDR_CFG, 32'h04100800);
        step(9'h00C, 5);
        chk("pfc_xoff", 32'h081, {xoff_seen, 3'h0, n_fs == 1});
        step(9'h000, 5);
        chk("pfc_xon", 32'h081, {xon_seen, 3'h0, n_fs == 1});
        wr(FCC_ADDR_CFG, 32'h00000800);
        step(9'h008, 5);
        chk("pfc_off", 0, n_fs);
        wr(FCC_ADDR_CFG, 32'h20000000);
        rxf(1'h1, 1'h0, 8'h00, 8'h00);
        chk("inhibit", 1, n_inh);
        wr(FCC_ADDR_CFG, 32'h00000081);
        rxf(1'h1, 1'h0, 8'h00, 8'h00);
        chk("fwd_pause", 1, n_fwd);
        rxf(1'h0, 1'h1, 8'hFF, 8'h00);
        chk("fwd_pfc", 32'h100, {n_fwd[0], hold});
        wr(FCC_ADDR_CFG, 32'h02000081);
        rxf(1'h0, 1'h1, 8'hFF, 8'h00);
        chk("hold_on", 8'h81, hold);
        rd(FCC_ADDR_STATUS, 32'h00000081);
        rxf(1'h0, 1'h0, 8'h00, 8'h01);
        chk("hold_clear", 8'h80, hold);
        tally_and_finish();
    end
endmodule
bind fcc_flow_ctrl fcc_flow_ctrl_props #(.PFC_SUPPORT(PFC_SUPPORT)) props (.ref_clk_in,
    .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pause_req_in,
    .tx_prio3_hold_valid, .rx_pause_frame_in, .rx_pfc_frame_in, .rx_pfc_quanta_valid_in,
    .tx_pause_send_out, .tx_pause_xon_out, .tx_pfc_send_out, .tx_pfc_xoff_out,
    .tx_inhibit_out, .rx_fwd_to_client_out, .rx_prio1_hold_valid, .rx_prio0_hold_valid);
